// ==== common/pulse_gate_pkg.sv ====
// Package: constants and types for the shaped RF pulse sequencer
package pulse_gate_pkg;

   // ==================================================================
   // Clock and widths
   // ==================================================================
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CNT_W         = 32;
   localparam int DLY_W         = 16;
   localparam int STEP_W        = 16;
   localparam int ADDR_W        = 8;
   localparam int PHASE_W       = 8;
   localparam int SAMPLE_W      = 8;
   localparam int WORD_W        = 2 * SAMPLE_W;
   localparam int FIFO_DEPTH    = 16;

   typedef logic [CNT_W-1:0] cnt_t;

   // ==================================================================
   // Times in ns as printed, and their cycle counts
   // ==================================================================
   localparam int MIN_PULSE_NS     = 200;
   localparam int ACB_START_OVH_NS = 10750;
   localparam int ACB_END_OVH_NS   = 4300;
   localparam int OUT_START_OVH_NS = 10950;
   localparam int OUT_END_OVH_NS   = 4500;

   // Least times round up to whole cycles, never below one
   function automatic cnt_t ns_to_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return cnt_t'((c < 1) ? 1 : c);
   endfunction

   localparam cnt_t MIN_PULSE_CYC     = ns_to_cyc(MIN_PULSE_NS);
   localparam cnt_t ACB_START_OVH_CYC = ns_to_cyc(ACB_START_OVH_NS);
   localparam cnt_t ACB_END_OVH_CYC   = ns_to_cyc(ACB_END_OVH_NS);
   localparam cnt_t OUT_START_OVH_CYC = ns_to_cyc(OUT_START_OVH_NS);
   localparam cnt_t OUT_END_OVH_CYC   = ns_to_cyc(OUT_END_OVH_NS);

   localparam cnt_t CNT_ZERO = '0;
   localparam cnt_t CNT_ONE  = cnt_t'(1);

   // ==================================================================
   // Board variant and sequencer states
   // ==================================================================
   typedef enum logic {
      VAR_ACB = 1'b0,
      VAR_OUT = 1'b1
   } variant_t;

   // Gray codes along idle -> start -> pre -> pulse -> post -> end
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_PRE   = 3'h3,
      ST_PULSE = 3'h2,
      ST_POST  = 3'h6,
      ST_END   = 3'h7
   } seq_state_t;

endpackage

// ==== rtl/word_fifo.sv ====
// Module: flip-flop FIFO with valid/ready on both sides
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   // Filling side
   input  wire logic             s_valid_in,
   input  wire logic [WIDTH-1:0] s_data_in,
   output logic                  s_ready_out,
   // Draining side
   output logic                  m_valid_out,
   output logic [WIDTH-1:0]      m_data_out,
   input  wire logic             m_ready_in
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wptr;
      logic [PTR_W-1:0]            rptr;
      logic [CNT_W-1:0]            cnt;
      logic                        not_full;
   } fifo_st_t;

   fifo_st_t st_r;
   fifo_st_t st_nxt;
   logic     push;
   logic     pop;

   assign push        = s_valid_in && st_r.not_full;
   assign pop         = m_ready_in && (st_r.cnt != '0);
   assign s_ready_out = st_r.not_full;
   assign m_valid_out = (st_r.cnt != '0);
   assign m_data_out  = st_r.mem[st_r.rptr];

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wptr] = s_data_in;
         st_nxt.wptr = (st_r.wptr == LAST_PTR) ? '0 : st_r.wptr + 1'b1;
      end
      if (pop) begin
         st_nxt.rptr = (st_r.rptr == LAST_PTR) ? '0 : st_r.rptr + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
      st_nxt.not_full = (st_nxt.cnt != FULL_CNT);
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r          <= '0;
         st_r.not_full <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // word_fifo

// ==== rtl/step_timer.sv ====
// Module: periodic step timer, one pulse every len cycles while running
module step_timer
   import pulse_gate_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_b_in,
   // Control
   input  wire logic              run_in,
   input  wire logic [STEP_W-1:0] len_in,
   // Expiry pulse
   output logic                   expire_out
);
   typedef struct packed {
      logic [STEP_W-1:0] cnt;
      logic              expire;
   } tmr_st_t;

   tmr_st_t st_r;
   tmr_st_t st_nxt;

   assign expire_out = st_r.expire;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.expire = 1'b0;
      if (!run_in) begin
         st_nxt.cnt = '0;
      // A length of zero behaves as one cycle per step
      end else if (st_r.cnt + 1'b1 >= len_in) begin
         st_nxt.cnt    = '0;
         st_nxt.expire = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // step_timer

// ==== rtl/shaped_pulse_seq.sv ====
// Module: shaped RF pulse sequencer for the observe transmitter
module shaped_pulse_seq
   import pulse_gate_pkg::*;
(
   // Clock and reset
   input  wire logic                MCLK_IN,
   input  wire logic                RST_B_IN,
   // Pulse request
   input  wire logic                REQ_VALID_IN,
   output logic                     REQ_READY_OUT,
   input  wire logic [CNT_W-1:0]    REQ_WIDTH_IN,
   input  wire logic [DLY_W-1:0]    REQ_PRE_GATE_IN,
   input  wire logic [DLY_W-1:0]    REQ_POST_GATE_IN,
   input  wire logic [PHASE_W-1:0]  REQ_PHASE_IN,
   input  wire logic [ADDR_W-1:0]   REQ_SHAPE_ADDR_IN,
   input  wire logic [STEP_W-1:0]   REQ_STEP_IN,
   // Configuration
   input  wire logic                VARIANT_IN,
   input  wire logic                WFG_PRESENT_IN,
   // Table words for generator-less shaping
   input  wire logic                WORD_VALID_IN,
   input  wire logic [WORD_W-1:0]   WORD_DATA_IN,
   output logic                     WORD_READY_OUT,
   // Gating and shaping outputs
   output logic                     AMP_GATE_OUT,
   output logic                     TX_GATE_OUT,
   output logic [PHASE_W-1:0]       PHASE_OUT,
   output logic                     SHAPE_START_OUT,
   output logic [ADDR_W-1:0]        SHAPE_ADDR_OUT,
   output logic [SAMPLE_W-1:0]      ATTEN_OUT,
   output logic [SAMPLE_W-1:0]      FINE_PHASE_OUT,
   // Status
   output logic                     BUSY_OUT,
   output logic                     SKIPPED_OUT,
   output logic                     UNDERFLOW_OUT,
   input  wire logic                UNDERFLOW_CLR_IN
);

   // ==================================================================
   // Reset release
   // ==================================================================
   logic [1:0] rst_sync_r;
   logic       rst_b;

   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_r[1];

   // ==================================================================
   // State
   // ==================================================================
   typedef struct packed {
      seq_state_t          state;
      cnt_t                cnt;
      cnt_t                width;
      logic [DLY_W-1:0]    pre;
      logic [DLY_W-1:0]    post;
      logic [PHASE_W-1:0]  phase_req;
      logic [ADDR_W-1:0]   addr_req;
      logic [STEP_W-1:0]   step;
      logic                wfg;
      variant_t            variant;
      logic                ready;
      logic                busy;
      logic                skipped;
      logic                amp_gate;
      logic                tx_gate;
      logic [PHASE_W-1:0]  phase;
      logic                shape_start;
      logic [ADDR_W-1:0]   shape_addr;
      logic [SAMPLE_W-1:0] atten;
      logic [SAMPLE_W-1:0] fine_phase;
      logic                underflow;
   } seq_st_t;

   seq_st_t st_r;
   seq_st_t st_nxt;

   // ==================================================================
   // Table word buffer and step timing
   // ==================================================================
   logic              word_valid;
   logic [WORD_W-1:0] word_data;
   logic              word_pop;
   logic              step_run;
   logic              step_expire;

   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_word_fifo (
      .clk_in      (MCLK_IN),
      .rst_b_in    (rst_b),
      .s_valid_in  (WORD_VALID_IN),
      .s_data_in   (WORD_DATA_IN),
      .s_ready_out (WORD_READY_OUT),
      .m_valid_out (word_valid),
      .m_data_out  (word_data),
      .m_ready_in  (word_pop)
   );

   // Runs only in table mode, while the transmitter gate is open
   assign step_run = (st_r.state == ST_PULSE) && !st_r.wfg;

   step_timer u_step_timer (
      .clk_in     (MCLK_IN),
      .rst_b_in   (rst_b),
      .run_in     (step_run),
      .len_in     (st_r.step),
      .expire_out (step_expire)
   );

   // ==================================================================
   // Overhead lookup by board variant
   // ==================================================================
   function automatic cnt_t start_ovh(input variant_t v);
      return (v == VAR_OUT) ? OUT_START_OVH_CYC
                            : ACB_START_OVH_CYC;
   endfunction

   function automatic cnt_t end_ovh(input variant_t v);
      return (v == VAR_OUT) ? OUT_END_OVH_CYC
                            : ACB_END_OVH_CYC;
   endfunction

   // ==================================================================
   // Sequencer
   // ==================================================================
   logic enter_pulse;
   logic step_now;
   logic uf_set;

   always_comb begin
      st_nxt             = st_r;
      st_nxt.skipped     = 1'b0;
      st_nxt.shape_start = 1'b0;
      enter_pulse        = 1'b0;
      step_now           = 1'b0;
      word_pop           = 1'b0;
      uf_set             = 1'b0;

      case (st_r.state)
         ST_IDLE: begin
            if (REQ_VALID_IN && st_r.ready) begin
               st_nxt.width     = REQ_WIDTH_IN;
               st_nxt.pre       = REQ_PRE_GATE_IN;
               st_nxt.post      = REQ_POST_GATE_IN;
               // Sampled per request, never a fixed value
               st_nxt.phase_req = REQ_PHASE_IN;
               st_nxt.addr_req  = REQ_SHAPE_ADDR_IN;
               st_nxt.step      = REQ_STEP_IN;
               st_nxt.wfg       = WFG_PRESENT_IN;
               st_nxt.variant   = variant_t'(VARIANT_IN);
               if (REQ_WIDTH_IN < MIN_PULSE_CYC) begin
                  // No gates and no overhead at all
                  st_nxt.skipped = 1'b1;
               end else begin
                  st_nxt.state = ST_START;
                  st_nxt.cnt   = start_ovh(variant_t'(VARIANT_IN))
                                 - CNT_ONE;
                  st_nxt.ready = 1'b0;
                  st_nxt.busy  = 1'b1;
               end
            end
         end

         ST_START: begin
            if (st_r.cnt == CNT_ZERO) begin
               st_nxt.amp_gate = 1'b1;
               // Phase moves as the pre-gate delay begins
               st_nxt.phase    = st_r.phase_req;
               if (st_r.pre == '0) begin
                  enter_pulse = 1'b1;
               end else begin
                  st_nxt.state = ST_PRE;
                  st_nxt.cnt   = cnt_t'(st_r.pre) - CNT_ONE;
               end
            end else begin
               st_nxt.cnt = st_r.cnt - CNT_ONE;
            end
         end

         ST_PRE: begin
            if (st_r.cnt == CNT_ZERO) begin
               enter_pulse = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - CNT_ONE;
            end
         end

         ST_PULSE: begin
            step_now = step_expire;
            if (st_r.cnt == CNT_ZERO) begin
               st_nxt.tx_gate = 1'b0;
               step_now       = 1'b0;
               if (st_r.post == '0) begin
                  st_nxt.amp_gate = 1'b0;
                  st_nxt.state    = ST_END;
                  st_nxt.cnt      = end_ovh(st_r.variant) - CNT_ONE;
               end else begin
                  st_nxt.state = ST_POST;
                  st_nxt.cnt   = cnt_t'(st_r.post) - CNT_ONE;
               end
            end else begin
               st_nxt.cnt = st_r.cnt - CNT_ONE;
            end
         end

         ST_POST: begin
            if (st_r.cnt == CNT_ZERO) begin
               st_nxt.amp_gate = 1'b0;
               st_nxt.state    = ST_END;
               st_nxt.cnt      = end_ovh(st_r.variant) - CNT_ONE;
            end else begin
               st_nxt.cnt = st_r.cnt - CNT_ONE;
            end
         end

         ST_END: begin
            if (st_r.cnt == CNT_ZERO) begin
               st_nxt.state = ST_IDLE;
               st_nxt.ready = 1'b1;
               st_nxt.busy  = 1'b0;
            end else begin
               st_nxt.cnt = st_r.cnt - CNT_ONE;
            end
         end

         default: begin
            st_nxt.state    = ST_IDLE;
            st_nxt.ready    = 1'b1;
            st_nxt.busy     = 1'b0;
            st_nxt.amp_gate = 1'b0;
            st_nxt.tx_gate  = 1'b0;
         end
      endcase

      // Opening the transmitter gate for the requested width
      if (enter_pulse) begin
         st_nxt.state   = ST_PULSE;
         st_nxt.tx_gate = 1'b1;
         st_nxt.cnt     = st_r.width - CNT_ONE;
         if (st_r.wfg) begin
            // Shape already resides in generator memory
            st_nxt.shape_start = 1'b1;
            st_nxt.shape_addr  = st_r.addr_req;
         end else begin
            step_now = 1'b1;
         end
      end

      // Table-driven shaping: one word per step
      if (step_now && !st_r.wfg) begin
         if (word_valid) begin
            word_pop          = 1'b1;
            st_nxt.atten      = word_data[WORD_W-1:SAMPLE_W];
            st_nxt.fine_phase = word_data[SAMPLE_W-1:0];
         end else begin
            // Word due but buffer dry: previous values held
            uf_set = 1'b1;
         end
      end

      // Sticky; a new underflow beats a clear in the same cycle
      st_nxt.underflow = (st_r.underflow && !UNDERFLOW_CLR_IN)
                         || uf_set;
   end

   always_ff @(posedge MCLK_IN or negedge rst_b) begin
      if (!rst_b) begin
         st_r       <= '0;
         st_r.state <= ST_IDLE;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==================================================================
   // Outputs, all from the state register
   // ==================================================================
   assign REQ_READY_OUT   = st_r.ready;
   assign AMP_GATE_OUT    = st_r.amp_gate;
   assign TX_GATE_OUT     = st_r.tx_gate;
   assign PHASE_OUT       = st_r.phase;
   assign SHAPE_START_OUT = st_r.shape_start;
   assign SHAPE_ADDR_OUT  = st_r.shape_addr;
   assign ATTEN_OUT       = st_r.atten;
   assign FINE_PHASE_OUT  = st_r.fine_phase;
   assign BUSY_OUT        = st_r.busy;
   assign SKIPPED_OUT     = st_r.skipped;
   assign UNDERFLOW_OUT   = st_r.underflow;

endmodule // shaped_pulse_seq

// ==== tb/pulse_gate_properties.sv ====
// Checker: port timing relations of the shaped pulse sequencer
module pulse_gate_properties
   import pulse_gate_pkg::*;
(
   // Clock and reset
   input wire logic               MCLK_IN,
   input wire logic               RST_B_IN,
   // Request
   input wire logic               REQ_VALID_IN,
   input wire logic               REQ_READY_OUT,
   input wire logic [PHASE_W-1:0] REQ_PHASE_IN,
   input wire logic               VARIANT_IN,
   // Gating and status
   input wire logic               AMP_GATE_OUT,
   input wire logic               TX_GATE_OUT,
   input wire logic [PHASE_W-1:0] PHASE_OUT,
   input wire logic               SHAPE_START_OUT,
   input wire logic               SKIPPED_OUT,
   input wire logic               UNDERFLOW_OUT,
   input wire logic               UNDERFLOW_CLR_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==================================================================
   // Helper counters
   // ==================================================================
   // Tail count may wrap in long idle spans; only read at ready return
   logic [15:0]        head_r;
   logic [15:0]        tail_r;
   logic [PHASE_W-1:0] phase_r;

   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         head_r  <= 16'h0;
         tail_r  <= 16'h0;
         phase_r <= '0;
      end else begin
         head_r <= REQ_READY_OUT ? 16'h0 : head_r + 16'h1;
         tail_r <= AMP_GATE_OUT ? 16'h0 : tail_r + 16'h1;
         if (REQ_VALID_IN && REQ_READY_OUT) begin
            phase_r <= REQ_PHASE_IN;
         end
      end
   end

   // ==================================================================
   // Assertions
   // ==================================================================
   default clocking @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   skip_quiet_a: assert property (
      SKIPPED_OUT |-> REQ_READY_OUT && !AMP_GATE_OUT)
      else $error("skipped pulse left the sequencer busy");
   start_ovh_a: assert property (
      $rose(AMP_GATE_OUT) |-> cnt_t'(head_r) ==
         (VARIANT_IN ? OUT_START_OVH_CYC : ACB_START_OVH_CYC))
      else $error("start overhead length wrong");
   end_ovh_a: assert property (
      $rose(REQ_READY_OUT) |-> cnt_t'(tail_r) ==
         (VARIANT_IN ? OUT_END_OVH_CYC : ACB_END_OVH_CYC))
      else $error("end overhead length wrong");
   tx_in_amp_a: assert property (
      TX_GATE_OUT |-> AMP_GATE_OUT)
      else $error("transmitter gate open without amplifier gate");
   amp_first_a: assert property (
      $rose(TX_GATE_OUT) |-> $past(AMP_GATE_OUT))
      else $error("transmitter gate opened before amplifier gate");
   amp_hold_a: assert property (
      $fell(AMP_GATE_OUT) |-> !$past(TX_GATE_OUT))
      else $error("amplifier gate closed with transmitter gate");
   shape_start_a: assert property (
      SHAPE_START_OUT |-> $rose(TX_GATE_OUT))
      else $error("shape start apart from transmitter gate rise");
   phase_set_a: assert property (
      $rose(AMP_GATE_OUT) |-> PHASE_OUT == phase_r)
      else $error("phase differs from value taken with request");
   uflow_hold_a: assert property (
      UNDERFLOW_OUT && !UNDERFLOW_CLR_IN |=> UNDERFLOW_OUT)
      else $error("underflow flag dropped without clear");
endmodule // pulse_gate_properties

// ==== tb/rf_front_model.sv ====
// Model of the RF amplifier, transmitter and shape memory
module rf_front_model
   import pulse_gate_pkg::*;
(
   // Gating and shaping from the sequencer
   input  wire logic                clk_in,
   input  wire logic                amp_gate_in,
   input  wire logic                tx_gate_in,
   input  wire logic                shape_start_in,
   input  wire logic [ADDR_W-1:0]   shape_addr_in,
   input  wire logic [SAMPLE_W-1:0] atten_in,
   input  wire logic [SAMPLE_W-1:0] fine_phase_in,
   // Measurements
   output int                       pre_out,
   output int                       width_out,
   output int                       post_out,
   output logic [ADDR_W-1:0]        addr_out,
   output logic [WORD_W-1:0]        first_out,
   output int                       starts_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==================================================================
   // Edge timing
   // ==================================================================
   int   now = 0;
   int   t_amp = 0;
   int   t_tx = 0;
   int   t_off = 0;
   logic amp_q = 1'b0;
   logic tx_q = 1'b0;

   initial begin
      pre_out = 0;
      width_out = 0;
      post_out = 0;
      starts_out = 0;
      addr_out = '0;
      first_out = '0;
   end

   always @(posedge clk_in) begin
      now = now + 1;
      if (amp_gate_in && !amp_q) t_amp = now;
      if (tx_gate_in && !tx_q) begin
         pre_out <= now - t_amp;
         first_out <= {atten_in, fine_phase_in};
         t_tx = now;
      end
      if (!tx_gate_in && tx_q) begin
         width_out <= now - t_tx;
         t_off = now;
      end
      if (!amp_gate_in && amp_q) post_out <= now - t_off;
      // Every shape is resident from time zero, so any address plays
      if (shape_start_in) begin
         addr_out <= shape_addr_in;
         starts_out <= starts_out + 1;
      end
      amp_q = amp_gate_in;
      tx_q = tx_gate_in;
   end
endmodule // rf_front_model

// ==== tb/shaped_pulse_seq_bench.sv ====
// Testbench for the shaped RF pulse sequencer
module shaped_pulse_seq_bench
   import pulse_gate_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ==================================================================
   // Stimulus and observed signals
   // ==================================================================
   logic                mclk = 1'b0;
   logic                rst_b = 1'b0;
   logic                req_v = 1'b0;
   logic [CNT_W-1:0]    width = '0;
   logic [DLY_W-1:0]    pre = '0;
   logic [DLY_W-1:0]    post = '0;
   logic [PHASE_W-1:0]  phase = '0;
   logic [ADDR_W-1:0]   addr = '0;
   logic [STEP_W-1:0]   step = 16'h4;
   logic                variant = 1'b0;
   logic                wfg = 1'b0;
   logic                w_v = 1'b0;
   logic [WORD_W-1:0]   w_d = '0;
   logic                uf_clr = 1'b0;
   logic                req_rdy, w_rdy, amp, tx, start, busy, skip, uf;
   logic [PHASE_W-1:0]  ph_o;
   logic [ADDR_W-1:0]   addr_o, m_addr;
   logic [SAMPLE_W-1:0] atten, fine;
   logic [WORD_W-1:0]   m_first;
   int                  m_pre, m_w, m_post, m_starts;
   int                  n_errors = 0;
   int                  n_checks = 0;

   always #4 mclk = ~mclk;

   shaped_pulse_seq DUT (.MCLK_IN(mclk), .RST_B_IN(rst_b),
      .REQ_VALID_IN(req_v), .REQ_READY_OUT(req_rdy),
      .REQ_WIDTH_IN(width), .REQ_PRE_GATE_IN(pre),
      .REQ_POST_GATE_IN(post), .REQ_PHASE_IN(phase),
      .REQ_SHAPE_ADDR_IN(addr), .REQ_STEP_IN(step),
      .VARIANT_IN(variant), .WFG_PRESENT_IN(wfg),
      .WORD_VALID_IN(w_v), .WORD_DATA_IN(w_d), .WORD_READY_OUT(w_rdy),
      .AMP_GATE_OUT(amp), .TX_GATE_OUT(tx), .PHASE_OUT(ph_o),
      .SHAPE_START_OUT(start), .SHAPE_ADDR_OUT(addr_o),
      .ATTEN_OUT(atten), .FINE_PHASE_OUT(fine), .BUSY_OUT(busy),
      .SKIPPED_OUT(skip), .UNDERFLOW_OUT(uf),
      .UNDERFLOW_CLR_IN(uf_clr));

   rf_front_model u_front (.clk_in(mclk), .amp_gate_in(amp),
      .tx_gate_in(tx), .shape_start_in(start), .shape_addr_in(addr_o),
      .atten_in(atten), .fine_phase_in(fine), .pre_out(m_pre),
      .width_out(m_w), .post_out(m_post), .addr_out(m_addr),
      .first_out(m_first), .starts_out(m_starts));

   // ==================================================================
   // Shared tasks
   // ==================================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   function automatic logic [WORD_W-1:0] word(input int i);
      return 16'h1080 + WORD_W'(i) * 16'h0101;
   endfunction

   // Only called while idle, so the second edge always takes it
   task automatic issue(input logic v, input logic g,
      input logic [CNT_W-1:0] w, input logic [DLY_W-1:0] p,
      input logic [DLY_W-1:0] q, input logic [PHASE_W-1:0] ph);
      @(posedge mclk);
      variant <= v;
      wfg <= g;
      width <= w;
      pre <= p;
      post <= q;
      phase <= ph;
      addr <= ph + 8'h11;
      req_v <= 1'b1;
      @(posedge mclk);
      req_v <= 1'b0;
      phase <= ~ph;
   endtask

   task automatic wait_idle();
      int i;
      i = 0;
      repeat (3) @(posedge mclk);
      while (req_rdy !== 1'b1 && i < 5000) begin
         @(posedge mclk);
         i++;
      end
      if (i == 5000) n_errors++;
   endtask

   // ==================================================================
   // Scenarios
   // ==================================================================
   task automatic t_skip();
      int s;
      s = m_starts;
      @(posedge mclk);
      width <= 32'h18;
      req_v <= 1'b1;
      repeat (2) @(posedge mclk);
      check(skip, 1'b1);
      req_v <= 1'b0;
      @(posedge mclk);
      check(skip, 1'b1);
      check(req_rdy, 1'b1);
      repeat (30) @(posedge mclk);
      check(m_starts, s);
      check(amp, 1'b0);
   endtask

   task automatic t_pulse(input logic v, input logic [CNT_W-1:0] w,
      input logic [DLY_W-1:0] p, input logic [DLY_W-1:0] q,
      input logic [PHASE_W-1:0] ph);
      int s;
      s = m_starts;
      issue(v, 1'b1, w, p, q, ph);
      @(posedge mclk);
      check(busy, 1'b1);
      check(req_rdy, 1'b0);
      wait_idle();
      check(busy, 1'b0);
      check(m_pre, p);
      check(m_w, w);
      check(m_post, q);
      check(m_addr, ph + 8'h11);
      check(m_starts, s + 1);
      check(ph_o, ph);
   endtask

   task automatic t_table();
      for (int i = 0; i < 17; i++) begin
         @(posedge mclk);
         w_v <= 1'b1;
         w_d <= word(i);
      end
      @(posedge mclk);
      w_v <= 1'b0;
      check(w_rdy, 1'b0);
      issue(1'b0, 1'b0, 32'h40, 16'h2, 16'h2, 8'h0f);
      wait_idle();
      check(m_first, word(0));
      check({atten, fine}, word(15));
      check(uf, 1'b0);
      check(w_rdy, 1'b1);
   endtask

   task automatic t_uflow();
      issue(1'b0, 1'b0, 32'h40, 16'h2, 16'h2, 8'h3c);
      wait_idle();
      check(uf, 1'b1);
      check({atten, fine}, word(15));
      @(posedge mclk);
      uf_clr <= 1'b1;
      @(posedge mclk);
      uf_clr <= 1'b0;
      @(posedge mclk);
      check(uf, 1'b0);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      check(req_rdy, 1'b1);
      check(w_rdy, 1'b1);
      check(busy, 1'b0);
      t_skip();
      t_pulse(1'b0, 32'h19, 16'h3, 16'h5, 8'h5a);
      t_pulse(1'b1, 32'h64, 16'h1, 16'h1, 8'ha5);
      t_table();
      t_uflow();
      end_sim();
   end

   // Four sequences of about 2000 cycles each and one short skip test fit well inside this
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
endmodule // shaped_pulse_seq_bench

bind shaped_pulse_seq pulse_gate_properties u_chk (.MCLK_IN, .RST_B_IN,
   .REQ_VALID_IN, .REQ_READY_OUT, .REQ_PHASE_IN, .VARIANT_IN,
   .AMP_GATE_OUT, .TX_GATE_OUT, .PHASE_OUT, .SHAPE_START_OUT,
   .SKIPPED_OUT, .UNDERFLOW_OUT, .UNDERFLOW_CLR_IN);
